//--- src/i2cbe_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Data write when idle sets buffer full, starts counter, shifts byte out.
// - SDA changes after SCL low; low one period, released high one period.
// - Eighth falling edge clears buffer full and releases SDA for acknowledge.
// - Ninth bit level stored in ack status: 0 acknowledged, 1 not.
// - After ninth clock: event flag, counter stops, SCL low, SDA released.
// - Address is seven bits plus direction; ack sampled at ninth falling edge.
// - Data write during any sequence is dropped and sets write collision.
// - Start request completes with event flag; firmware then loads address.
// - Receive request clocks SCL per rollover, shifting SDA in each clock.
// - Eighth received falling edge: copy byte unless buffer full, flags set, SCL low, idle.
// - Reading the data buffer clears buffer full.
// - Byte completed while buffer still full sets receive overflow.
// - Ack request: SCL low, ack value on SDA, low period, high period.
// - Ack sequence end clears its request, stops counter, goes idle.
// - Firmware acks each byte; event flag after ack; ends with nack or stop.
// - Stop: SDA low, reload on SDA low, release SCL, then SDA a period later.
// - SDA high with SCL high sets stop seen; a period later event, request off.
// - Event flag rises once a stop or repeated start has completed.
// - Counter reloads from the 8-bit reload value; one countdown is a period.
// - Counter holds after SCL release until SCL is sampled high.
module i2cbe_engine
  import i2cbe_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             start_request,
  output logic             restart_request,
  input  wire logic        cond_done,
  output logic [7:0]       rate_reload_value
);
  import i2cbe_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  i2cbe_state_t state;
  i2cbe_state_t next_state;
  logic       scl_meta, scl_s, sda_meta, sda_s;
  logic [7:0] rate_counter;
  logic [7:0] shift_register;
  logic [7:0] data_buffer;
  logic [3:0] bitcnt;
  logic       buffer_full_flag, write_collision_flag, receive_overflow_flag;
  logic       port_event_flag, stop_seen, ack_status_bit, ack_value_bit;
  logic       stop_request, receive_request, ack_sequence_request;
  logic       next_scl_oe, next_sda_oe, load_cnt, bit_adv, rx_sample;
  logic       tx_byte_end, tx_ack_end, rx_end, ack_end;
  logic       stop_seen_set, stop_end, ext_end, leave_idle;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc      = psel & penable & pready;
  wire hit_data = (paddr == OFS_DATA);
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_rld  = (paddr == OFS_RELOAD);
  wire mapped   = hit_data | hit_ctrl | hit_stat | hit_rld;
  wire wr_data  = acc & pwrite & hit_data;
  wire rd_data  = acc & ~pwrite & hit_data;
  wire wr_ctrl  = acc & pwrite & hit_ctrl;
  wire wr_stat  = acc & pwrite & hit_stat;
  wire wr_rld   = acc & pwrite & hit_rld;
  wire any_req  = start_request | restart_request | stop_request
                | receive_request | ack_sequence_request;
  wire busy     = (state != S_IDLE) | any_req;
  wire wr_ok    = wr_data & ~busy;
  wire write_collision_flag_set = wr_data & busy;
  wire ctrl_ok  = wr_ctrl & ~busy;
  wire evt_set  = ext_end | tx_ack_end | rx_end | ack_end | stop_end;
  wire counting = (state == S_TX_LOW) | (state == S_TX_HIGH)
                | (state == S_RX_LOW) | (state == S_RX_HIGH)
                | (state == S_AK_LOW) | (state == S_AK_HIGH)
                | (state == S_SP_LOW) | (state == S_SP_HIGH)
                | (state == S_SP_END);
  wire tick     = counting & (rate_counter == 8'h00);

  wire [31:0] ctrl_word = {25'h000_0000, ack_status_bit, ack_value_bit,
    ack_sequence_request, receive_request, stop_request,
    restart_request, start_request};
  wire [31:0] stat_word = {26'h000_0000, busy, stop_seen, port_event_flag,
    receive_overflow_flag, write_collision_flag, buffer_full_flag};
  wire [31:0] rd_word = hit_data ? {24'h00_0000, data_buffer} :
                        hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word :
                        hit_rld  ? {24'h00_0000, rate_reload_value} :
                        32'h0000_0000;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= rd_word;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      scl_s    <= scl_meta;
      sda_meta <= sda_i;
      sda_s    <= sda_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state    = state;
    next_scl_oe   = scl_oe;
    next_sda_oe   = sda_oe;
    load_cnt      = 1'b0;
    bit_adv       = 1'b0;
    rx_sample     = 1'b0;
    tx_byte_end   = 1'b0;
    tx_ack_end    = 1'b0;
    rx_end        = 1'b0;
    ack_end       = 1'b0;
    stop_seen_set = 1'b0;
    stop_end      = 1'b0;
    ext_end       = 1'b0;
    case (state)
      S_IDLE:
        if (wr_ok)
        begin
          next_scl_oe = 1'b1;
          load_cnt    = 1'b1;
          next_state  = S_TX_LOW;
        end
        else if (start_request | restart_request)
          next_state = S_EXT;
        else if (stop_request)
        begin
          next_scl_oe = 1'b1;
          next_sda_oe = 1'b1;
          next_state  = S_SP_SDA;
        end
        else if (receive_request)
        begin
          next_scl_oe = 1'b1;
          next_sda_oe = 1'b0;
          load_cnt    = 1'b1;
          next_state  = S_RX_LOW;
        end
        else if (ack_sequence_request)
        begin
          next_scl_oe = 1'b1;
          next_sda_oe = ~ack_value_bit;
          load_cnt    = 1'b1;
          next_state  = S_AK_LOW;
        end
      S_EXT:
        if (cond_done)
        begin
          ext_end    = 1'b1;
          next_state = S_IDLE;
        end
      S_TX_LOW:
      begin
        // SDA moves one cycle after SCL went low
        next_sda_oe = (bitcnt == BIT_NINTH) ? 1'b0 : ~shift_register[7];
        if (tick)
        begin
          next_scl_oe = 1'b0;
          next_state  = S_TX_WAIT;
        end
      end
      S_TX_WAIT:
        if (scl_s)
        begin
          load_cnt   = 1'b1;
          next_state = S_TX_HIGH;
        end
      S_TX_HIGH:
        if (tick)
        begin
          next_scl_oe = 1'b1;
          bit_adv     = 1'b1;
          if (bitcnt == BIT_NINTH)
          begin
            tx_ack_end = 1'b1;
            next_state = S_IDLE;
          end
          else
          begin
            tx_byte_end = (bitcnt == BIT_EIGHTH);
            load_cnt    = 1'b1;
            next_state  = S_TX_LOW;
          end
        end
      S_RX_LOW:
        if (tick)
        begin
          next_scl_oe = 1'b0;
          next_state  = S_RX_WAIT;
        end
      S_RX_WAIT:
        if (scl_s)
        begin
          rx_sample  = 1'b1;
          load_cnt   = 1'b1;
          next_state = S_RX_HIGH;
        end
      S_RX_HIGH:
        if (tick)
        begin
          next_scl_oe = 1'b1;
          bit_adv     = 1'b1;
          if (bitcnt == BIT_EIGHTH)
          begin
            rx_end     = 1'b1;
            next_state = S_IDLE;
          end
          else
          begin
            load_cnt   = 1'b1;
            next_state = S_RX_LOW;
          end
        end
      S_AK_LOW:
        if (tick)
        begin
          next_scl_oe = 1'b0;
          next_state  = S_AK_WAIT;
        end
      S_AK_WAIT:
        if (scl_s)
        begin
          load_cnt   = 1'b1;
          next_state = S_AK_HIGH;
        end
      S_AK_HIGH:
        if (tick)
        begin
          next_scl_oe = 1'b1;
          ack_end     = 1'b1;
          next_state  = S_IDLE;
        end
      S_SP_SDA:
        if (!sda_s)
        begin
          load_cnt   = 1'b1;
          next_state = S_SP_LOW;
        end
      S_SP_LOW:
        if (tick)
        begin
          next_scl_oe = 1'b0;
          next_state  = S_SP_WAIT;
        end
      S_SP_WAIT:
        if (scl_s)
        begin
          load_cnt   = 1'b1;
          next_state = S_SP_HIGH;
        end
      S_SP_HIGH:
        if (tick)
        begin
          next_sda_oe = 1'b0;
          next_state  = S_SP_SEEN;
        end
      S_SP_SEEN:
        if (sda_s & scl_s)
        begin
          stop_seen_set = 1'b1;
          load_cnt      = 1'b1;
          next_state    = S_SP_END;
        end
      S_SP_END:
        if (tick)
        begin
          stop_end   = 1'b1;
          next_state = S_IDLE;
        end
      default:
        next_state = S_IDLE;
    endcase
  end

  assign leave_idle = (state == S_IDLE) & (next_state != S_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state  <= S_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  // ----------------------------------------------------------------
  // Rate counter: one period is reload value plus one cycles
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rate_counter <= RELOAD_RST;
    else if (load_cnt)
      rate_counter <= rate_reload_value;
    else if (counting && rate_counter != 8'h00)
      rate_counter <= rate_counter - 8'h01;
  end

  // ----------------------------------------------------------------
  // Shifter and bit count
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_register <= 8'h00;
      bitcnt         <= 4'h0;
    end
    else
    begin
      if (wr_ok)
        shift_register <= pwdata[7:0];
      else if (rx_sample)
        shift_register <= {shift_register[6:0], sda_s};
      else if (bit_adv && state == S_TX_HIGH)
        shift_register <= {shift_register[6:0], 1'b0};
      if (leave_idle)
        bitcnt <= 4'h0;
      else if (bit_adv)
        bitcnt <= bitcnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Data buffer and flags; hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_buffer           <= 8'h00;
      buffer_full_flag      <= 1'b0;
      write_collision_flag  <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_event_flag       <= 1'b0;
      stop_seen             <= 1'b0;
      ack_status_bit        <= 1'b0;
    end
    else
    begin
      // An overrun byte is dropped so firmware keeps the older one
      if (wr_ok || (rx_end && !buffer_full_flag))
        data_buffer <= wr_ok ? pwdata[7:0] : shift_register;
      if (wr_ok || rx_end)
        buffer_full_flag <= 1'b1;
      else if (tx_byte_end || rd_data)
        buffer_full_flag <= 1'b0;
      if (write_collision_flag_set)
        write_collision_flag <= 1'b1;
      else if (wr_stat && pwdata[ST_WRITE_COLLISION_FLAG])
        write_collision_flag <= 1'b0;
      if (rx_end && buffer_full_flag)
        receive_overflow_flag <= 1'b1;
      else if (wr_stat && pwdata[ST_OVF])
        receive_overflow_flag <= 1'b0;
      if (evt_set)
        port_event_flag <= 1'b1;
      else if (wr_stat && pwdata[ST_EVT])
        port_event_flag <= 1'b0;
      if (stop_seen_set)
        stop_seen <= 1'b1;
      else if (leave_idle)
        stop_seen <= 1'b0;
      if (tx_ack_end)
        ack_status_bit <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Control register two and reload value
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_request        <= 1'b0;
      restart_request      <= 1'b0;
      stop_request         <= 1'b0;
      receive_request      <= 1'b0;
      ack_sequence_request <= 1'b0;
      ack_value_bit        <= 1'b0;
      rate_reload_value    <= RELOAD_RST;
    end
    else
    begin
      if (wr_ctrl)
        ack_value_bit <= pwdata[CT_ACKVAL];
      if (wr_rld)
        rate_reload_value <= pwdata[7:0];
      if (ctrl_ok)
      begin
        start_request        <= pwdata[CT_START];
        restart_request      <= pwdata[CT_RESTART];
        stop_request         <= pwdata[CT_STOP];
        receive_request      <= pwdata[CT_RECV];
        ack_sequence_request <= pwdata[CT_ACKREQ];
      end
      else
      begin
        if (ext_end)
        begin
          start_request   <= 1'b0;
          restart_request <= 1'b0;
        end
        if (stop_end)
          stop_request <= 1'b0;
        if (rx_end)
          receive_request <= 1'b0;
        if (ack_end)
          ack_sequence_request <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_write_start: assert property (wr_ok |=> buffer_full_flag && state == S_TX_LOW && scl_oe)
    else $error("data write did not start transmit");
  a_tx_low_hold: assert property (state == S_TX_LOW |-> scl_oe)
    else $error("scl released during low phase");
  a_bf_eighth: assert property (tx_byte_end |=> !buffer_full_flag ##1 !sda_oe)
    else $error("eighth edge did not clear bf or release sda");
  a_ack_capture: assert property (tx_ack_end |=> ack_status_bit == $past(sda_s))
    else $error("ack status mismatch");
  a_tx_suspend: assert property (tx_ack_end |=> port_event_flag && scl_oe && !sda_oe && state == S_IDLE ##1 rate_counter == $past(rate_counter))
    else $error("engine not suspended after ninth clock");
  a_write_collision_flag_keep: assert property (write_collision_flag_set |=> write_collision_flag && data_buffer == $past(data_buffer))
    else $error("collision write not dropped");
  a_rx_finish: assert property (rx_end |=> buffer_full_flag && port_event_flag && !receive_request && scl_oe && state == S_IDLE)
    else $error("receive end wrong");
  a_read_clear: assert property (rd_data && !rx_end |=> !buffer_full_flag)
    else $error("read did not clear bf");
  a_overflow: assert property (rx_end && buffer_full_flag |=> receive_overflow_flag)
    else $error("overflow not flagged");
  a_ack_drive: assert property (state == S_IDLE && next_state == S_AK_LOW |=> sda_oe == !$past(ack_value_bit) && scl_oe)
    else $error("ack value not driven");
  a_stop_finish: assert property (stop_seen_set |-> ##[1:257] stop_end)
    else $error("stop did not finish");
  a_wait_hold: assert property (state == S_TX_WAIT && !scl_s |=> rate_counter == $past(rate_counter))
    else $error("counter ran while scl low");
  a_reload: assert property (load_cnt |=> rate_counter == $past(rate_reload_value))
    else $error("counter not reloaded");

  c_tx_byte: cover property (tx_ack_end);
  c_rx_ovf: cover property (rx_end && buffer_full_flag);
  c_ack_seq: cover property (ack_end);
  c_stop_seq: cover property (stop_end);
endmodule
`default_nettype wire

//--- src/i2cbe_pkg.sv
`default_nettype none
package i2cbe_pkg;
  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  // ----------------------------------------------------------------
  // Control register two fields
  // ----------------------------------------------------------------
  localparam int CT_START   = 0;
  localparam int CT_RESTART = 1;
  localparam int CT_STOP    = 2;
  localparam int CT_RECV    = 3;
  localparam int CT_ACKREQ  = 4;
  localparam int CT_ACKVAL  = 5;
  localparam int CT_ACK_STATUS_BIT = 6;
  // ----------------------------------------------------------------
  // Port status register fields
  // ----------------------------------------------------------------
  localparam int ST_BF   = 0;
  localparam int ST_WRITE_COLLISION_FLAG = 1;
  localparam int ST_OVF  = 2;
  localparam int ST_EVT  = 3;
  localparam int ST_STOP = 4;
  localparam int ST_BUSY = 5;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [3:0] BIT_EIGHTH = 4'h7;
  localparam logic [3:0] BIT_NINTH  = 4'h8;
  typedef enum logic [4:0] {
    S_IDLE, S_EXT,
    S_TX_LOW, S_TX_WAIT, S_TX_HIGH,
    S_RX_LOW, S_RX_WAIT, S_RX_HIGH,
    S_AK_LOW, S_AK_WAIT, S_AK_HIGH,
    S_SP_SDA, S_SP_LOW, S_SP_WAIT, S_SP_HIGH, S_SP_SEEN, S_SP_END
  } i2cbe_state_t;
endpackage
`default_nettype wire

//--- sim/i2cbe_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Slave device on the two-wire bus
// ------------------------------------------------------------
module i2cbe_slave_model
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       arm,
  input  wire logic       rd_mode,
  input  wire logic       nack,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic            rx_ack
);
  int cnt = 0;

  initial
  begin
    scl_pull = 1'b0;
    rx_byte = 8'h00;
    rx_ack = 1'b0;
  end

  // Armed only once the master holds SCL low, so a bus left high is not miscounted
  always @(posedge arm or negedge scl)
    if (arm)
      cnt <= 0;
    else
      cnt <= (cnt == 8) ? 0 : cnt + 1;

  // Stretching lengthens the low phase beyond the master's own count
  always @(negedge scl)
    if (slow)
    begin
      scl_pull = 1'b1;
      #100;
      scl_pull = 1'b0;
    end

  always @(posedge scl)
    if (cnt < 8)
      rx_byte <= {rx_byte[6:0], sda};
    else
      rx_ack <= sda;

  // Open drain: zeros are pulled, ones are left to the pull-up
  assign sda_pull = rd_mode ? (cnt < 8 && !tx_byte[7 - cnt]) : (cnt == 8 && !nack);
endmodule
`default_nettype wire

//--- sim/test_i2c_master_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_byte_engine;
  import i2cbe_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cond_done = 0;
  logic        arm = 0, rd_mode = 0, nack = 0, slow = 0, err;
  logic [7:0]  paddr = 0, tx_byte = 0, rx_byte;
  logic [31:0] pwdata = 0, rd, prdata;
  logic        pready, pslverr, scl_oe, sda_oe, start_request, scl_pull, sda_pull, rx_ack;
  logic        restart_request;
  logic [7:0]  rate_reload_value;
  logic [15:0] seed = 16'h24DA;
  logic [7:0]  q[$];
  int          miscompares = 0, n_checks = 0;
  wire logic   scl, sda;

  assign scl = !(scl_oe || scl_pull);
  assign sda = !(sda_oe || sda_pull);
  always #4 pclk = ~pclk;

  i2cbe_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .start_request(start_request), .restart_request(restart_request),
    .cond_done(cond_done), .rate_reload_value(rate_reload_value));

  i2cbe_slave_model slave_u (.scl(scl), .sda(sda), .arm(arm), .rd_mode(rd_mode),
    .nack(nack), .slow(slow), .tx_byte(tx_byte), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .rx_byte(rx_byte), .rx_ack(rx_ack));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polling is bounded so a lost event cannot hang the run
  task wait_evt;
    int k;
    k = 0;
    do
    begin
      apb(0, OFS_STATUS, 0);
      k++;
    end
    while (rd[ST_EVT] !== 1'b1 && k < 500);
    chk("event", 1, rd[ST_EVT]);
  endtask

  task go(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    repeat (2) @(posedge pclk);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask

  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    results;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_STATUS, 0);
    chk("status rst", 0, rd);
    apb(0, OFS_RELOAD, 0);
    chk("reload rst", {24'h0, RELOAD_RST}, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 1, err);
    apb(1, OFS_RELOAD, 32'h0000_0004);
    apb(0, OFS_RELOAD, 0);
    chk("reload", 4, rd);
    chk("reload pin", 4, rate_reload_value);
    apb(1, OFS_CTRL, 32'h0000_0001);
    @(posedge pclk);
    chk("start req", 1, start_request);
    cond_done <= 1'b1;
    @(posedge pclk);
    cond_done <= 1'b0;
    wait_evt;
    chk("start done", 0, start_request);
    apb(1, OFS_STATUS, 32'h0000_000E);
    go(OFS_DATA, 32'h0000_00A1);
    apb(0, OFS_STATUS, 0);
    chk("bf tx", 1, rd[ST_BF]);
    apb(1, OFS_DATA, 32'h0000_0055);
    wait_evt;
    chk("addr byte", 8'hA1, rx_byte);
    chk("bf clear", 0, rd[ST_BF]);
    chk("write_collision_flag", 1, rd[ST_WRITE_COLLISION_FLAG]);
    chk("scl sda", 2'b01, {scl, sda});
    apb(0, OFS_CTRL, 0);
    chk("ack_status_bit", 0, rd[CT_ACK_STATUS_BIT]);
    apb(1, OFS_STATUS, 32'h0000_000E);
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      nack <= i[0];
      slow <= i[0];
      go(OFS_DATA, {24'h0, seed[7:0]});
      wait_evt;
      chk("data byte", seed[7:0], rx_byte);
      apb(0, OFS_CTRL, 0);
      chk("ack_status_bit", i[0], rd[CT_ACK_STATUS_BIT]);
      apb(1, OFS_STATUS, 32'h0000_000E);
    end
    slow <= 1'b0;
    rd_mode <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      tx_byte <= seed[7:0];
      go(OFS_CTRL, 32'h0000_0008);
      apb(1, OFS_DATA, 0);
      apb(1, OFS_CTRL, 32'h0000_0004);
      wait_evt;
      chk("overflow", q.size(), rd[ST_OVF]);
      chk("write_collision_flag rx", 1, rd[ST_WRITE_COLLISION_FLAG]);
      chk("bf rx", 1, rd[ST_BF]);
      if (q.size() == 0)
        q.push_back(tx_byte);
      apb(0, OFS_CTRL, 0);
      chk("ctrl rx", 0, rd[CT_RECV:CT_STOP]);
      if (i != 1)
      begin
        apb(0, OFS_DATA, 0);
        chk("rx byte", q.pop_front(), rd);
        apb(0, OFS_STATUS, 0);
        chk("bf read", 0, rd[ST_BF]);
      end
      apb(1, OFS_STATUS, 32'h0000_000E);
      apb(1, OFS_CTRL, {26'h0, i[0], 5'h10});
      wait_evt;
      chk("ack sent", i[0], rx_ack);
      apb(0, OFS_CTRL, 0);
      chk("ack req", 0, rd[CT_ACKREQ]);
      apb(1, OFS_STATUS, 32'h0000_000E);
    end
    rd_mode <= 1'b0;
    nack <= 1'b1;
    // Repeated start is handed to the outside generator like a start
    apb(1, OFS_CTRL, 32'h0000_0002);
    @(posedge pclk);
    chk("restart req", 1, restart_request);
    cond_done <= 1'b1;
    @(posedge pclk);
    cond_done <= 1'b0;
    wait_evt;
    chk("restart done", 0, restart_request);
    apb(1, OFS_STATUS, 32'h0000_000E);
    apb(1, OFS_CTRL, 32'h0000_0004);
    wait_evt;
    chk("stop seen", 1, rd[ST_STOP]);
    chk("bus free", 2'b11, {scl, sda});
    apb(0, OFS_CTRL, 0);
    chk("stop req", 0, rd[CT_STOP]);
    results;
  end
endmodule
`default_nettype wire
